// ==== rtl/vic_consts.svh ====
// Register offsets, field positions, reset values and sizes of the interrupt source control
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH
`define VIC_NSRC          32
`define VIC_SMR_BASE      12'h000
`define VIC_SVR_BASE      12'h080
`define VIC_IVR_OFF       12'h100
`define VIC_FVR_OFF       12'h104
`define VIC_ISR_OFF       12'h108
`define VIC_IPR_OFF       12'h10C
`define VIC_IMR_OFF       12'h110
`define VIC_CISR_OFF      12'h114
`define VIC_IECR_OFF      12'h120
`define VIC_IDCR_OFF      12'h124
`define VIC_ICCR_OFF      12'h128
`define VIC_ISCR_OFF      12'h12C
`define VIC_EOICR_OFF     12'h130
`define VIC_SPU_OFF       12'h134
`define VIC_DCR_OFF       12'h138
`define VIC_FFER_OFF      12'h140
`define VIC_FFDR_OFF      12'h144
`define VIC_FFSR_OFF      12'h148
`define VIC_SMR_PRIO_LSB  0
`define VIC_SMR_TYPE_LSB  5
`define VIC_DCR_GMSK_BIT  1
`define VIC_CISR_FAST_BIT 0
`define VIC_CISR_STD_BIT  1
`define VIC_SMR_RESET     5'h00
`define VIC_STACK_DEPTH   8
`endif

// ==== rtl/vic_pkg.sv ====
// Types shared by the interrupt source control
package vic_pkg;
  typedef enum logic [1:0] {
    VIC_TRIG_LEVEL_LOW  = 2'b00,
    VIC_TRIG_EDGE_FALL  = 2'b01,
    VIC_TRIG_LEVEL_HIGH = 2'b10,
    VIC_TRIG_EDGE_RISE  = 2'b11
  } vic_trig_t;

  typedef struct packed {
    vic_trig_t  trig;
    logic [2:0] prio;
  } vic_smr_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } vic_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } vic_apb_rsp_t;

  typedef struct packed {
    logic [4:0] src;
    logic [2:0] lvl;
  } vic_stk_t;
endpackage

// ==== rtl/vic_source_ctrl.sv ====
// Source control, priority and request drive of the vectored interrupt controller
`timescale 1ns/1ps
`include "vic_consts.svh"

module vic_source_ctrl
  import vic_pkg::*;
#(
  parameter int          NEXT   = 4,
  parameter logic [31:0] EXTMAP = 32'hF000_0001
) (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire vic_pkg::vic_apb_req_t apbReq,
  output vic_pkg::vic_apb_rsp_t      apbRsp,
  input  wire logic                fast_irq_pin,
  input  wire logic [NEXT-1:0]     ext_irq_pins,
  input  wire logic [31:0]         periphIrq,
  input  wire logic [31:0]         sysIrqLines,
  output logic                     fast_irq_out_n,
  output logic                     std_irq_out_n,
  output logic                     wakeReq
);
  import vic_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] best_src(input logic [31:0] act, input vic_smr_t m [32]);
    logic [5:0] best;
    logic [2:0] bl;
    best = 6'h20;
    bl   = 3'h0;
    for (int i = 0; i < 32; i++) begin
      if (act[i] && (best[5] || m[i].prio > bl)) begin
        best = 6'(i);
        bl   = m[i].prio;
      end
    end
    return best;
  endfunction

  function automatic logic is_edge(input vic_trig_t t);
    return t[0];
  endfunction

  // ----------------------------------------------------------------
  // Source inputs and synchronisers
  // ----------------------------------------------------------------
  logic [31:0] rawSrc;
  logic [31:0] syncA, syncB, prevLvl;
  always_comb begin
    rawSrc    = periphIrq;
    rawSrc[0] = fast_irq_pin;
    rawSrc[1] = |sysIrqLines;
    for (int k = 0; k < NEXT; k++) begin
      rawSrc[32-NEXT+k] = ext_irq_pins[k];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncA   <= 32'h0000_0000;
      syncB   <= 32'h0000_0000;
      prevLvl <= 32'h0000_0000;
    end else begin
      syncA   <= rawSrc;
      syncB   <= syncA;
      prevLvl <= syncB;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  vic_smr_t    smr [32];
  vic_smr_t    next_smr [32];
  logic [31:0] svr [32];
  logic [31:0] next_svr [32];
  logic [31:0] mask, next_mask, edgeMem, next_edgeMem, force_, next_force;
  logic [31:0] spu, next_spu;
  logic        gmask, next_gmask;
  vic_stk_t    stk [`VIC_STACK_DEPTH];
  vic_stk_t    next_stk [`VIC_STACK_DEPTH];
  logic [3:0]  sp, next_sp;
  logic        fastOutN, next_fastOutN, stdOutN, next_stdOutN, wake, next_wake;
  vic_apb_rsp_t rsp, next_rsp;

  // Effective trigger: internal sources only use level-high or rising
  vic_trig_t   trig [32];
  logic [31:0] edgeHit, levelAct, pend, active, edgeSel;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (EXTMAP[i]) begin
        trig[i] = smr[i].trig;
      end else begin
        trig[i] = is_edge(smr[i].trig) ? VIC_TRIG_EDGE_RISE : VIC_TRIG_LEVEL_HIGH;
      end
      unique case (trig[i])
        VIC_TRIG_EDGE_RISE:  edgeHit[i] = syncB[i] & ~prevLvl[i];
        VIC_TRIG_EDGE_FALL:  edgeHit[i] = ~syncB[i] & prevLvl[i];
        VIC_TRIG_LEVEL_HIGH: edgeHit[i] = 1'b0;
        VIC_TRIG_LEVEL_LOW:  edgeHit[i] = 1'b0;
      endcase
      levelAct[i] = (trig[i] == VIC_TRIG_LEVEL_HIGH) ? syncB[i] : ~syncB[i];
      pend[i]     = is_edge(trig[i]) ? edgeMem[i] : levelAct[i];
      edgeSel[i]  = is_edge(trig[i]);
    end
    active = pend & mask;
  end

  // ----------------------------------------------------------------
  // Priority
  // ----------------------------------------------------------------
  logic [31:0] stdAct;
  logic [5:0]  cand;
  logic [2:0]  curLvl;
  logic [4:0]  curSrc;
  logic        inSvc;
  logic        eligible;
  always_comb begin
    stdAct = active & ~force_;
    // Source 0 only ever takes the fast path
    stdAct[0] = 1'b0;
    cand   = best_src(stdAct, smr);
    inSvc  = (sp != 4'h0);
    curLvl = inSvc ? stk[sp[2:0] - 3'h1].lvl : 3'h0;
    curSrc = inSvc ? stk[sp[2:0] - 3'h1].src : 5'h00;
    // A candidate must beat the level under service
    eligible = !cand[5] && (!inSvc || smr[cand[4:0]].prio > curLvl);
  end

  // ----------------------------------------------------------------
  // Bus and state update
  // ----------------------------------------------------------------
  logic        acc, take, wr, rd;
  logic [11:0] adr;
  logic [31:0] wd;
  assign acc  = apbReq.psel & apbReq.penable;
  // Only the first access edge is taken, so the edge at which the master
  // sees pready never repeats a vector read or an end of service
  assign take = acc & ~rsp.pready;
  assign wr   = take & apbReq.pwrite;
  assign rd   = take & ~apbReq.pwrite;
  assign adr = apbReq.paddr;
  assign wd  = apbReq.pwdata;

  always_comb begin
    next_smr     = smr;
    next_svr     = svr;
    next_mask    = mask;
    next_force   = force_;
    next_spu     = spu;
    next_gmask   = gmask;
    next_stk     = stk;
    next_sp      = sp;
    next_rsp     = '{prdata: 32'h0000_0000, pready: 1'b1, pslverr: 1'b0};
    next_edgeMem = edgeMem;
    if (wr) begin
      if (adr < `VIC_SVR_BASE && adr[1:0] == 2'b00) begin
        next_smr[adr[6:2]] = vic_smr_t'({wd[6:5], wd[2:0]});
      end else if (adr >= `VIC_SVR_BASE && adr < `VIC_IVR_OFF) begin
        next_svr[adr[6:2]] = wd;
      end else begin
        unique case (adr)
          `VIC_IECR_OFF: next_mask = mask | wd;
          `VIC_IDCR_OFF: next_mask = mask & ~wd;
          `VIC_ISCR_OFF: next_edgeMem = edgeMem | (wd & edgeSel);
          `VIC_ICCR_OFF: next_edgeMem = edgeMem & ~(wd & edgeSel);
          `VIC_EOICR_OFF: if (inSvc) next_sp = sp - 4'h1;
          `VIC_SPU_OFF:  next_spu = wd;
          `VIC_DCR_OFF:  next_gmask = wd[`VIC_DCR_GMSK_BIT];
          `VIC_FFER_OFF: next_force = force_ | (wd & 32'hFFFF_FFFE);
          `VIC_FFDR_OFF: next_force = force_ & ~wd;
          default:       next_rsp.pslverr = 1'b1;
        endcase
      end
    end
    if (rd) begin
      if (adr < `VIC_SVR_BASE && adr[1:0] == 2'b00) begin
        next_rsp.prdata = {25'h0, smr[adr[6:2]].trig, 2'b00, smr[adr[6:2]].prio};
      end else if (adr >= `VIC_SVR_BASE && adr < `VIC_IVR_OFF) begin
        next_rsp.prdata = svr[adr[6:2]];
      end else begin
        unique case (adr)
          `VIC_IVR_OFF: begin
            if (eligible) begin
              next_rsp.prdata = svr[cand[4:0]];
              // Push the new source and its level
              next_stk[sp[2:0]] = '{src: cand[4:0], lvl: smr[cand[4:0]].prio};
              if (sp != 4'(`VIC_STACK_DEPTH)) next_sp = sp + 4'h1;
              if (is_edge(trig[cand[4:0]])) next_edgeMem[cand[4:0]] = 1'b0;
            end else begin
              next_rsp.prdata = spu;
            end
          end
          `VIC_FVR_OFF: begin
            next_rsp.prdata = svr[0];
            if (is_edge(trig[0])) next_edgeMem[0] = 1'b0;
          end
          `VIC_ISR_OFF:  next_rsp.prdata = {27'h0, curSrc};
          `VIC_IPR_OFF:  next_rsp.prdata = pend;
          `VIC_IMR_OFF:  next_rsp.prdata = mask;
          `VIC_CISR_OFF: next_rsp.prdata = {30'h0, ~std_irq_out_n, ~fast_irq_out_n};
          `VIC_SPU_OFF:  next_rsp.prdata = spu;
          `VIC_DCR_OFF:  next_rsp.prdata = {30'h0, gmask, 1'b0};
          `VIC_FFSR_OFF: next_rsp.prdata = force_;
          default:       next_rsp.pslverr = 1'b1;
        endcase
      end
    end
    // Hardware edge capture wins over every clear
    for (int i = 0; i < 32; i++) begin
      if (edgeHit[i]) next_edgeMem[i] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Request outputs
  // ----------------------------------------------------------------
  logic fastCond, stdCond, ivrRd;
  always_comb begin
    ivrRd    = rd && adr == `VIC_IVR_OFF;
    fastCond = active[0] | (|(active & force_));
    stdCond  = eligible && !ivrRd;
    // Lines are held active low in their flops
    next_fastOutN = ~(fastCond & ~gmask);
    next_stdOutN  = ~(stdCond & ~gmask);
    next_wake     = fastCond | stdCond;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) begin
        smr[i] <= vic_smr_t'(`VIC_SMR_RESET);
        svr[i] <= 32'h0000_0000;
      end
      for (int j = 0; j < `VIC_STACK_DEPTH; j++) begin
        stk[j] <= '{src: 5'h00, lvl: 3'h0};
      end
      mask    <= 32'h0000_0000;
      edgeMem <= 32'h0000_0000;
      force_  <= 32'h0000_0000;
      spu     <= 32'h0000_0000;
      gmask   <= 1'b0;
      sp      <= 4'h0;
      // Request lines idle high
      fastOutN <= 1'b1;
      stdOutN  <= 1'b1;
      wake    <= 1'b0;
      rsp     <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      smr     <= next_smr;
      svr     <= next_svr;
      stk     <= next_stk;
      mask    <= next_mask;
      edgeMem <= next_edgeMem;
      force_  <= next_force;
      spu     <= next_spu;
      gmask   <= next_gmask;
      sp      <= next_sp;
      fastOutN <= next_fastOutN;
      stdOutN  <= next_stdOutN;
      wake    <= next_wake;
      rsp     <= take ? next_rsp : '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end
  end

  // APB answers one cycle into the access phase
  assign apbRsp         = rsp;
  assign fast_irq_out_n = fastOutN;
  assign std_irq_out_n  = stdOutN;
  assign wakeReq        = wake;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  std_after_ivr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ivrRd |=> std_irq_out_n) else $error("standard request not dropped by vector read");
  gmask_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    gmask |=> (std_irq_out_n && fast_irq_out_n)) else $error("request while globally masked");
  iecr_sets_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr && adr == `VIC_IECR_OFF) |=> ((mask & $past(wd)) == $past(wd)))
    else $error("enable command lost");
  set_level_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr && adr == `VIC_ISCR_OFF)
      |=> ((edgeMem & ~$past(edgeSel)) == ($past(edgeMem) & ~$past(edgeSel))))
    else $error("set command reached a level source");
  edge_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|edgeHit) |=> ((edgeMem & $past(edgeHit)) == $past(edgeHit)))
    else $error("edge not memorized");
  fvr_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rd && adr == `VIC_FVR_OFF && is_edge(trig[0]) && !edgeHit[0]) |=> !edgeMem[0])
    else $error("fast vector read left source 0 set");
  fast_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (active[0] && !gmask) |=> !fast_irq_out_n) else $error("fast request missing");
  eoi_pop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr && adr == `VIC_EOICR_OFF && inSvc && !ivrRd) |=> (sp == $past(sp) - 4'h1))
    else $error("end of service did not pop");
  wake_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (active[0]) |=> wakeReq) else $error("no wake on fast source");
  clear_level_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr && adr == `VIC_ICCR_OFF)
      |=> ((edgeMem & ~$past(edgeSel)) == ($past(edgeMem) & ~$past(edgeSel))))
    else $error("clear command reached a level source");
  mask_drop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr && adr == `VIC_IDCR_OFF) |=> ((mask & $past(wd)) == 32'h0000_0000))
    else $error("disable command lost");
  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (active == 32'h0000_0000) |=> (std_irq_out_n && fast_irq_out_n))
    else $error("request with no enabled pending source");
  sys_or_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|sysIrqLines) |=> syncA[1])
    else $error("system lines not combined into source 1");

  // ----------------------------------------------------------------
  // Service assertions
  // ----------------------------------------------------------------
  nest_push_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ivrRd && eligible) |=> (sp == $past(sp) + 4'h1 && curSrc == $past(cand[4:0])))
    else $error("vector read did not push the new source");
  prio_high_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ivrRd && eligible) |=> (curLvl == $past(smr[cand[4:0]].prio)))
    else $error("current level is not the taken priority");
  vec_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ivrRd && eligible && edgeSel[cand[4:0]] && !edgeHit[cand[4:0]])
      |=> !edgeMem[$past(cand[4:0])])
    else $error("vector read left the current edge set");
  force_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ivrRd && |(edgeMem & force_))
      |=> ((edgeMem & $past(edgeMem & force_)) == $past(edgeMem & force_)))
    else $error("vector read cleared a fast-forced source");
  spur_nopush_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ivrRd && !eligible) |=> (sp == $past(sp)))
    else $error("spurious vector read changed the stack");

  // ----------------------------------------------------------------
  // Read-back assertions
  // ----------------------------------------------------------------
  cur_report_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rd && adr == `VIC_ISR_OFF) |=> (apbRsp.prdata == {27'h0, $past(curSrc)}))
    else $error("current source read-back wrong");
  line_image_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rd && adr == `VIC_CISR_OFF)
      |=> (apbRsp.prdata[1:0] == $past({~std_irq_out_n, ~fast_irq_out_n})))
    else $error("line image read-back wrong");
  pend_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rd && adr == `VIC_IPR_OFF) |=> (apbRsp.prdata == $past(pend)))
    else $error("pending read-back wrong");
  fvr_vector_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rd && adr == `VIC_FVR_OFF) |=> (apbRsp.prdata == $past(svr[0])))
    else $error("fast vector read-back wrong");

endmodule // vic_source_ctrl

// ==== verification/vectored_interrupt_source_control_test.sv ====
// Self-checking bench of the interrupt source control
`timescale 1ns/1ps
`include "vic_consts.svh"
module vectored_interrupt_source_control_test;
  import vic_pkg::*;
  typedef struct {logic wr; logic [11:0] addr; logic [31:0] data;} vic_row_t;
  logic                  clk_sys, nrst, fastPin, fastN, stdN, wakeReq, err;
  logic [3:0]            extPins;
  logic [31:0]           periphIrq, sysIrqLines, rd;
  logic [7:0]            wakeCount;
  vic_apb_req_t          req;
  vic_apb_rsp_t          rsp;
  int                    bad_count, samples_checked;
  vic_row_t rows [6] = '{'{1'b1, `VIC_IECR_OFF, 32'h0000_0F0C},
    '{1'b0, `VIC_IMR_OFF, 32'h0000_0F0C}, '{1'b1, `VIC_IDCR_OFF, 32'h0000_0F0C},
    '{1'b0, `VIC_IMR_OFF, 32'h0000_0000}, '{1'b1, 12'h014, 32'h0000_0065},
    '{1'b0, 12'h014, 32'h0000_0065}};

  vic_source_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .apbReq(req), .apbRsp(rsp),
    .fast_irq_pin(fastPin), .ext_irq_pins(extPins), .periphIrq(periphIrq),
    .sysIrqLines(sysIrqLines), .fast_irq_out_n(fastN), .std_irq_out_n(stdN),
    .wakeReq(wakeReq));
  vic_core_model core (.clk_sys(clk_sys), .nrst(nrst), .fastReqN(fastN),
    .stdReqN(stdN), .wakeReq(wakeReq), .wakeCount(wakeCount));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    // Ready is sampled at the rising edge; data is taken at that same edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end else begin
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  task automatic waitLow(input logic fast);
    int n;
    n = 0;
    while ((fast ? fastN : stdN) !== 1'b0 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    samples_checked = 0;
    nrst = 1'b0;
    req = '0;
    fastPin = 1'b1;
    extPins = 4'hF;
    periphIrq = 32'h0000_0000;
    sysIrqLines = 32'h0000_0000;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    check("fast line", fastN, 32'h1);
    check("std line", stdN, 32'h1);
    rdchk("pending", `VIC_IPR_OFF, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].data);
      else rdchk("row", rows[i].addr, rows[i].data);
    end
    $display("row test done");
    wr(12'h00C, 32'h60);
    wr(12'h010, 32'h40);
    wr(`VIC_ISCR_OFF, 32'h18);
    rdchk("edge set", `VIC_IPR_OFF, 32'h08);
    wr(`VIC_ICCR_OFF, 32'h18);
    rdchk("edge clear", `VIC_IPR_OFF, 32'h0);
    $display("edge test done");
    wr(12'h00C, 32'h62);
    wr(`VIC_SVR_BASE + 12'h00C, 32'h333);
    wr(`VIC_SVR_BASE + 12'h014, 32'h555);
    wr(`VIC_IECR_OFF, 32'h28);
    wr(`VIC_ISCR_OFF, 32'h28);
    waitLow(1'b0);
    rdchk("line image", `VIC_CISR_OFF, 32'h2);
    rdchk("vector", `VIC_IVR_OFF, 32'h555);
    rdchk("current", `VIC_ISR_OFF, 32'h5);
    rdchk("auto clear", `VIC_IPR_OFF, 32'h08);
    repeat (6) @(negedge clk_sys);
    check("std held off", stdN, 32'h1);
    wr(`VIC_EOICR_OFF, 32'h0);
    waitLow(1'b0);
    rdchk("vector low", `VIC_IVR_OFF, 32'h333);
    wr(`VIC_EOICR_OFF, 32'h0);
    for (int s = 8; s < 10; s++) begin
      wr(12'(4 * s), 32'h64);
      wr(`VIC_SVR_BASE + 12'(4 * s), 32'(s));
    end
    wr(`VIC_IECR_OFF, 32'h300);
    wr(`VIC_ISCR_OFF, 32'h300);
    for (int s = 8; s < 10; s++) begin
      waitLow(1'b0);
      rdchk("tie vector", `VIC_IVR_OFF, 32'(s));
      wr(`VIC_EOICR_OFF, 32'h0);
    end
    $display("priority test done");
    wr(12'h028, 32'h60);
    wr(`VIC_FFER_OFF, 32'h400);
    wr(`VIC_IECR_OFF, 32'h400);
    wr(`VIC_ISCR_OFF, 32'h400);
    waitLow(1'b1);
    rdchk("fast image", `VIC_CISR_OFF, 32'h1);
    apb(1'b0, `VIC_IVR_OFF, 32'h0);
    rdchk("forced kept", `VIC_IPR_OFF, 32'h400);
    wr(`VIC_ICCR_OFF, 32'h400);
    wr(`VIC_FFDR_OFF, 32'h400);
    wr(12'h000, 32'h20);
    wr(`VIC_IECR_OFF, 32'h1);
    fastPin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    fastPin <= 1'b1;
    waitLow(1'b1);
    rdchk("source0", `VIC_IPR_OFF, 32'h1);
    apb(1'b0, `VIC_FVR_OFF, 32'h0);
    rdchk("fast clear", `VIC_IPR_OFF, 32'h0);
    $display("fast test done");
    wr(12'h004, 32'h40);
    wr(12'h070, 32'h20);
    sysIrqLines <= 32'h80;
    extPins <= 4'hE;
    repeat (5) @(posedge clk_sys);
    extPins <= 4'hF;
    rdchk("sys and pin", `VIC_IPR_OFF, 32'h1000_0002);
    check("masked pin quiet", stdN, 32'h1);
    sysIrqLines <= 32'h0;
    wr(`VIC_ICCR_OFF, 32'h1000_0000);
    $display("source test done");
    wr(`VIC_DCR_OFF, 32'h2);
    wr(`VIC_IECR_OFF, 32'h10);
    periphIrq <= 32'h10;
    repeat (6) @(posedge clk_sys);
    check("std masked", stdN, 32'h1);
    check("wake", wakeReq, 32'h1);
    check("core woke", 32'(wakeCount != 8'h00), 32'h1);
    periphIrq <= 32'h0;
    apb(1'b0, 12'h200, 32'h0);
    check("unmapped error", err, 32'h1);
    apb(1'b1, `VIC_IPR_OFF, 32'h1);
    check("read-only error", err, 32'h1);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk("mask after reset", `VIC_IMR_OFF, 32'h0);
    $display("error and reset test done");
    report_and_stop();
  end
endmodule // vectored_interrupt_source_control_test

// ==== verification/vic_core_model.sv ====
// Processor core side model: watches the request lines and counts wake-ups
`timescale 1ns/1ps
module vic_core_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       fastReqN,
  input  wire logic       stdReqN,
  input  wire logic       wakeReq,
  output logic [7:0]      wakeCount
);
  logic asleep;
  // Idle core leaves idle on either request line or the wake line
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      asleep    <= 1'b1;
      wakeCount <= 8'h00;
    end else if (asleep && (!fastReqN || !stdReqN || wakeReq)) begin
      asleep    <= 1'b0;
      wakeCount <= wakeCount + 8'h01;
    end else if (fastReqN && stdReqN && !wakeReq) begin
      asleep <= 1'b1;
    end
  end
endmodule // vic_core_model
